// >>> logic/rsdm_register_store.sv
// Register store with data mapper, validity timers and fallback
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - store is made of 16-bit registers
// - register numbers 1 to 65536, subset implemented
// - byte uses one register, dword uses two
// - words held with low byte first
// - eight simple map entries per interface
// - simple targets packed from area start
// - simple source is equal-length input span
// - swap flag exchanges bytes of copied words
// - extended target and source given bitwise
// - simple entries first, then extended, overwrite
// - producers fill inputs, engine fills outputs
// - per-producer validity timer restarted on delivery
// - stale source replaced by consumer policy
// - validity times and policies survive restart
// - map edits apply only after restart
// - serial data port inputs 0x1401 to 0x1500
// - shift port inputs start at 0x1001
// - fieldbus outputs start at 0x2801
// - serial master reads inputs and outputs, writes only configuration
// - shift port write restarts its timer
module rsdm_register_store #(
	parameter int AREA_WORDS = 256,
	parameter int TICK_DIV = rsdm_pkg::TICK_CYCLES
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [16:0] regAddr,
	input wire logic [15:0] regWrData,
	input wire logic regWr,
	input wire logic regRd,
	output logic [15:0] regRdData,
	input wire logic [2:0] prodWr,
	input wire logic [2:0][7:0] prodAddr,
	input wire logic [2:0][1:0] prodSize,
	input wire logic [2:0][31:0] prodData,
	input wire logic [2:0] conRd,
	input wire logic [2:0][7:0] conAddr,
	output logic [2:0][15:0] conRdData,
	output logic [2:0] dataValid,
	output logic mapCycleDone
);
	localparam int AW = $clog2(AREA_WORDS);
	// Finds the process area holding a register number
	function automatic rsdm_pkg::rsdm_loc_s locate(input logic [16:0] a,
			input logic isOut);
		rsdm_pkg::rsdm_loc_s loc;
		logic [16:0] base, diff;
		loc = '0;
		for (int i = 0; i < rsdm_pkg::NIF; i++) begin
			base = isOut ? rsdm_pkg::OUT_BASE[i] : rsdm_pkg::IN_BASE[i];
			diff = a - base;
			if (a >= base && diff < 17'(AREA_WORDS)) begin
				loc.hit = 1'b1;
				loc.ifc = 2'(i);
				loc.off = diff[15:0];
			end
		end
		return loc;
	endfunction
	// Process data areas, one array per direction
	rsdm_pkg::rsdm_word_t inMem_q [rsdm_pkg::NIF][AREA_WORDS];
	rsdm_pkg::rsdm_word_t outMem_q [rsdm_pkg::NIF][AREA_WORDS];
	// Live configuration, edited by software
	logic [15:0] validTime_q [rsdm_pkg::NIF], policy_q [rsdm_pkg::NIF];
	logic [15:0] smSrc_q [rsdm_pkg::NIF][rsdm_pkg::NUM_SMAP];
	logic [15:0] smCnt_q [rsdm_pkg::NIF][rsdm_pkg::NUM_SMAP];
	logic [15:0] emTgt_q [rsdm_pkg::NUM_EMAP];
	logic [15:0] emSrc_q [rsdm_pkg::NUM_EMAP];
	logic [15:0] emPos_q [rsdm_pkg::NUM_EMAP];
	logic [15:0] emCnt_q [rsdm_pkg::NUM_EMAP];
	// Active map copies, taken only at restart
	logic [15:0] aSmSrc_q [rsdm_pkg::NIF][rsdm_pkg::NUM_SMAP];
	logic [15:0] aSmCnt_q [rsdm_pkg::NIF][rsdm_pkg::NUM_SMAP];
	logic [15:0] aEmTgt_q [rsdm_pkg::NUM_EMAP];
	logic [15:0] aEmSrc_q [rsdm_pkg::NUM_EMAP];
	logic [15:0] aEmPos_q [rsdm_pkg::NUM_EMAP];
	logic [15:0] aEmCnt_q [rsdm_pkg::NUM_EMAP];
	logic restartPend_q; // Load active maps next cycle
	// Validity timers
	logic [31:0] tickCnt_q;
	logic tick;
	logic [15:0] age_q [rsdm_pkg::NIF];
	logic [2:0] fresh_q;
	// Mapping engine state
	rsdm_pkg::rsdm_state_e state_q;
	logic [1:0] ifc_q;
	logic [3:0] ent_q;
	logic [14:0] word_q;
	logic [10:0] bit_q;
	logic [15:0] tgtOff_q;
	// Engine datapath
	logic [16:0] srcAddr, tgtAddr;
	logic [20:0] srcPos, tgtPos;
	logic [14:0] curCnt;
	logic [10:0] curBits;
	logic active;
	rsdm_pkg::rsdm_loc_s srcLoc;
	rsdm_pkg::rsdm_loc_s tgtLoc;
	logic [15:0] srcWord;
	logic srcOk;
	logic [1:0] tgtPol;
	logic doWrite;
	logic [15:0] wrWord;
	logic wrBit;
	// Register bus decode
	rsdm_pkg::rsdm_loc_s busIn, busOut;
	logic [15:0] busRdVal;
	// Producer deliveries into the input areas
	always_ff @(posedge clock) begin
		for (int p = 0; p < rsdm_pkg::NIF; p++) begin
			if (prodWr[p]) begin
				case (prodSize[p])
					2'h0: begin // Byte, upper byte written as zero
						inMem_q[p][prodAddr[p][AW-1:0]] <= {8'h00, prodData[p][7:0]};
					end
					2'h2: begin // Dword, low word at lower register
						inMem_q[p][prodAddr[p][AW-1:0]] <= prodData[p][15:0];
						if (32'(prodAddr[p]) + 32'h1 < 32'(AREA_WORDS)) begin
							inMem_q[p][AW'(prodAddr[p] + 8'h01)] <= prodData[p][31:16];
						end
					end
					default: begin // Plain word
						inMem_q[p][prodAddr[p][AW-1:0]] <= prodData[p][15:0];
					end
				endcase
			end
		end
	end
	// Millisecond tick for the validity timers
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			tickCnt_q <= '0;
		end else if (tickCnt_q >= 32'(TICK_DIV - 1)) begin
			tickCnt_q <= '0;
		end else begin
			tickCnt_q <= tickCnt_q + 32'h1;
		end
	end
	assign tick = (tickCnt_q >= 32'(TICK_DIV - 1));
	// Age and freshness of each producer's data
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			fresh_q <= '0;
			for (int p = 0; p < rsdm_pkg::NIF; p++) begin
				age_q[p] <= '0;
			end
		end else begin
			for (int p = 0; p < rsdm_pkg::NIF; p++) begin
				if (prodWr[p]) begin // Delivery wins over expiry
					age_q[p] <= '0;
					fresh_q[p] <= 1'b1;
				end else if (tick && fresh_q[p]) begin
					if (age_q[p] + 16'h1 >= validTime_q[p]) begin
						fresh_q[p] <= 1'b0;
					end
					age_q[p] <= age_q[p] + 16'h1;
				end
			end
		end
	end
	// Disabled timer means data never goes stale
	always_comb begin
		for (int p = 0; p < rsdm_pkg::NIF; p++) begin
			dataValid[p] = (validTime_q[p] == 16'h0000) || fresh_q[p];
		end
	end
	// Software writes to the configuration registers
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			for (int i = 0; i < rsdm_pkg::NIF; i++) begin
				validTime_q[i] <= rsdm_pkg::VALID_TIME_RST;
				policy_q[i] <= rsdm_pkg::POLICY_RST;
				for (int e = 0; e < rsdm_pkg::NUM_SMAP; e++) begin
					smSrc_q[i][e] <= '0;
					smCnt_q[i][e] <= '0;
				end
			end
			for (int e = 0; e < rsdm_pkg::NUM_EMAP; e++) begin
				emTgt_q[e] <= '0;
				emSrc_q[e] <= '0;
				emPos_q[e] <= '0;
				emCnt_q[e] <= '0;
			end
		end else if (regWr) begin
			// Times and policies live apart from the restart path
			for (int i = 0; i < rsdm_pkg::NIF; i++) begin
				if (regAddr == rsdm_pkg::CFG_VALID_TIME + 17'(i)) begin
					validTime_q[i] <= regWrData;
				end
				if (regAddr == rsdm_pkg::CFG_POLICY + 17'(i)) begin
					policy_q[i] <= regWrData;
				end
			end
			// Simple map: interface in [5:4], entry in [3:1]
			if (regAddr[16:6] == rsdm_pkg::CFG_SMAP[16:6] &&
					regAddr[5:4] != 2'h3) begin
				if (regAddr[0]) begin
					smCnt_q[regAddr[5:4]][regAddr[3:1]] <= regWrData;
				end else begin
					smSrc_q[regAddr[5:4]][regAddr[3:1]] <= regWrData;
				end
			end
			// Extended map: entry in [5:2], field in [1:0]
			if (regAddr[16:6] == rsdm_pkg::CFG_EMAP[16:6]) begin
				case (regAddr[1:0])
					2'h0: emTgt_q[regAddr[5:2]] <= regWrData;
					2'h1: emSrc_q[regAddr[5:2]] <= regWrData;
					2'h2: emPos_q[regAddr[5:2]] <= regWrData;
					default: emCnt_q[regAddr[5:2]] <= regWrData;
				endcase
			end
		end
	end
	// Restart request: pending out of reset and on command
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			restartPend_q <= 1'b1;
		end else begin
			restartPend_q <= regWr && (regAddr == rsdm_pkg::CFG_RESTART);
		end
	end
	// Active maps only change at a restart
	always_ff @(posedge clock) begin
		if (restartPend_q) begin
			aSmSrc_q <= smSrc_q;
			aSmCnt_q <= smCnt_q;
			aEmTgt_q <= emTgt_q;
			aEmSrc_q <= emSrc_q;
			aEmPos_q <= emPos_q;
			aEmCnt_q <= emCnt_q;
		end
	end
	// Engine datapath: one word or one bit per cycle
	always_comb begin
		curCnt = aSmCnt_q[ifc_q][ent_q[2:0]][14:0];
		curBits = (aEmCnt_q[ent_q][10:0] > rsdm_pkg::EXT_MAX_BITS) ?
			rsdm_pkg::EXT_MAX_BITS : aEmCnt_q[ent_q][10:0];
		srcPos = {aEmSrc_q[ent_q], 4'h0} + 21'(aEmPos_q[ent_q][7:4]) +
			21'(bit_q);
		tgtPos = {aEmTgt_q[ent_q], 4'h0} + 21'(aEmPos_q[ent_q][3:0]) +
			21'(bit_q);
		if (state_q == rsdm_pkg::ST_SIMPLE) begin
			active = (word_q < curCnt) && (ifc_q != 2'h3);
			srcAddr = 17'(aSmSrc_q[ifc_q][ent_q[2:0]]) + 17'(word_q);
			tgtAddr = rsdm_pkg::OUT_BASE[ifc_q] + 17'(tgtOff_q);
		end else begin
			active = bit_q < curBits;
			srcAddr = srcPos[20:4];
			tgtAddr = tgtPos[20:4];
		end
		srcLoc = locate(srcAddr, 1'b0);
		tgtLoc = locate(tgtAddr, 1'b1);
		// Sources outside the input areas read as zero
		srcWord = srcLoc.hit ? inMem_q[srcLoc.ifc][srcLoc.off[AW-1:0]] : 16'h0000;
		srcOk = !srcLoc.hit || dataValid[srcLoc.ifc];
		tgtPol = policy_q[tgtLoc.ifc][1:0];
		// Keep policy simply skips the write
		doWrite = active && tgtLoc.hit &&
			(srcOk || (tgtPol == rsdm_pkg::POL_ZERO) ||
			(tgtPol == rsdm_pkg::POL_ONES));
		if (!srcOk) begin
			wrWord = (tgtPol == rsdm_pkg::POL_ONES) ? 16'hFFFF : 16'h0000;
		end else if (aSmCnt_q[ifc_q][ent_q[2:0]][rsdm_pkg::SWAP_BIT]) begin
			wrWord = {srcWord[7:0], srcWord[15:8]};
		end else begin
			wrWord = srcWord;
		end
		wrBit = srcOk ? srcWord[srcPos[3:0]] : wrWord[0];
	end
	// Engine sequencing: all simple entries, then all extended
	always_ff @(posedge clock) begin
		if (!rst_n || restartPend_q) begin
			state_q <= rsdm_pkg::ST_SIMPLE;
			ifc_q <= '0;
			ent_q <= '0;
			word_q <= '0;
			bit_q <= '0;
			tgtOff_q <= '0;
			mapCycleDone <= 1'b0;
		end else begin
			mapCycleDone <= 1'b0;
			case (state_q)
				rsdm_pkg::ST_SIMPLE: begin
					if (active) begin
						word_q <= word_q + 15'h1;
						tgtOff_q <= tgtOff_q + 16'h1; // Spans back to back
					end else begin
						word_q <= '0;
						if (ent_q[2:0] == 3'(rsdm_pkg::NUM_SMAP - 1)) begin
							ent_q <= '0;
							tgtOff_q <= '0;
							if (ifc_q == 2'(rsdm_pkg::NIF - 1)) begin
								ifc_q <= '0;
								state_q <= rsdm_pkg::ST_EXT;
							end else begin
								ifc_q <= ifc_q + 2'h1;
							end
						end else begin
							ent_q <= ent_q + 4'h1;
						end
					end
				end
				rsdm_pkg::ST_EXT: begin
					if (active) begin
						bit_q <= bit_q + 11'h1;
					end else begin
						bit_q <= '0;
						ent_q <= ent_q + 4'h1;
						if (ent_q == 4'(rsdm_pkg::NUM_EMAP - 1)) begin
							state_q <= rsdm_pkg::ST_SIMPLE;
							mapCycleDone <= 1'b1;
						end
					end
				end
				default: begin
					state_q <= rsdm_pkg::ST_SIMPLE;
				end
			endcase
		end
	end
	// Output areas: only the engine writes them
	always_ff @(posedge clock) begin
		if (doWrite) begin
			if (state_q == rsdm_pkg::ST_SIMPLE) begin
				outMem_q[tgtLoc.ifc][tgtLoc.off[AW-1:0]] <= wrWord;
			end else begin
				// Later entries overwrite earlier bits
				outMem_q[tgtLoc.ifc][tgtLoc.off[AW-1:0]][tgtPos[3]]
					[tgtPos[2:0]] <= wrBit;
			end
		end
	end
	// Consumers fetch their output words, data one cycle later
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			conRdData <= '0;
		end else begin
			for (int c = 0; c < rsdm_pkg::NIF; c++) begin
				if (conRd[c]) begin
					conRdData[c] <= outMem_q[c][conAddr[c][AW-1:0]];
				end
			end
		end
	end
	// Register bus read mux; unmapped numbers read zero
	always_comb begin
		busIn = locate(regAddr, 1'b0);
		busOut = locate(regAddr, 1'b1);
		busRdVal = 16'h0000;
		if (busIn.hit) begin
			busRdVal = inMem_q[busIn.ifc][busIn.off[AW-1:0]];
		end else if (busOut.hit) begin
			busRdVal = outMem_q[busOut.ifc][busOut.off[AW-1:0]];
		end else if (regAddr == rsdm_pkg::CFG_STATUS) begin
			busRdVal = {12'h000, state_q == rsdm_pkg::ST_EXT, dataValid};
		end else if (regAddr[16:6] == rsdm_pkg::CFG_SMAP[16:6] &&
				regAddr[5:4] != 2'h3) begin
			busRdVal = regAddr[0] ? smCnt_q[regAddr[5:4]][regAddr[3:1]] :
				smSrc_q[regAddr[5:4]][regAddr[3:1]];
		end else if (regAddr[16:6] == rsdm_pkg::CFG_EMAP[16:6]) begin
			case (regAddr[1:0])
				2'h0: busRdVal = emTgt_q[regAddr[5:2]];
				2'h1: busRdVal = emSrc_q[regAddr[5:2]];
				2'h2: busRdVal = emPos_q[regAddr[5:2]];
				default: busRdVal = emCnt_q[regAddr[5:2]];
			endcase
		end else begin
			for (int i = 0; i < rsdm_pkg::NIF; i++) begin
				if (regAddr == rsdm_pkg::CFG_VALID_TIME + 17'(i)) begin
					busRdVal = validTime_q[i];
				end
				if (regAddr == rsdm_pkg::CFG_POLICY + 17'(i)) begin
					busRdVal = policy_q[i];
				end
			end
		end
	end
	// Read data register, changes only after a read strobe
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			regRdData <= '0;
		end else if (regRd) begin
			regRdData <= busRdVal;
		end
	end
endmodule
`default_nettype wire

// >>> logic/rsdm_pkg.sv
// Shared constants and types of the register store and data mapper
`default_nettype none
package rsdm_pkg;
	// Interface indices: fieldbus, serial data port, synchronous shift port
	localparam int NIF = 3;
	localparam int IF_FB = 0;
	localparam int IF_SDP = 1;
	localparam int IF_SSP = 2;
	// Register numbers are 1..65536, so 17 bits of address
	localparam int REG_ADDR_W = 17;
	localparam logic [16:0] REG_LAST = 17'h10000;
	// Process data area bases, indexed by interface
	localparam logic [16:0] IN_BASE [NIF] = '{17'h02401, 17'h01401, 17'h01001};
	localparam logic [16:0] OUT_BASE [NIF] = '{17'h02801, 17'h01801, 17'h01201};
	// Serial data port input area ends here (256 words)
	localparam logic [16:0] SDP_IN_LAST = 17'h01500;
	// Mapping table sizes and limits
	localparam int NUM_SMAP = 8;
	localparam int NUM_EMAP = 16;
	localparam logic [10:0] EXT_MAX_BITS = 11'h400;
	localparam int SWAP_BIT = 15;
	localparam logic [15:0] SWAP_FLAG = 16'h8000;
	// Configuration register numbers
	localparam logic [16:0] CFG_RESTART = 17'h00010;
	localparam logic [16:0] CFG_VALID_TIME = 17'h00011;
	localparam logic [16:0] CFG_POLICY = 17'h00014;
	localparam logic [16:0] CFG_STATUS = 17'h00017;
	localparam logic [16:0] CFG_SMAP = 17'h00100;
	localparam logic [16:0] CFG_EMAP = 17'h00200;
	// Reset values of the configuration
	localparam logic [15:0] VALID_TIME_RST = 16'h0000;
	localparam logic [15:0] POLICY_RST = 16'h0000;
	// Fallback policy codes
	localparam logic [1:0] POL_ZERO = 2'h0;
	localparam logic [1:0] POL_ONES = 2'h1;
	localparam logic [1:0] POL_KEEP = 2'h2;
	// Validity timer tick: one millisecond
	localparam int CLK_PERIOD_NS = 5;
	localparam int VALID_TICK_NS = 1000000;
	localparam int TICK_CYCLES = VALID_TICK_NS / CLK_PERIOD_NS;
	// One store word, byte lane 0 is the low byte (little endian)
	typedef logic [1:0][7:0] rsdm_word_t;
	// Where an address falls inside a process data area
	typedef struct packed {
		logic hit;
		logic [1:0] ifc;
		logic [15:0] off;
	} rsdm_loc_s;
	// Mapping engine phases
	typedef enum logic [0:0] {ST_SIMPLE, ST_EXT} rsdm_state_e;
endpackage
`default_nettype wire

// >>> verification/rsdm_checker.sv
// Port checker for the register store and data mapper
`timescale 1ns/1ps
`default_nettype none
module rsdm_checker (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [16:0] regAddr,
	input wire logic regWr,
	input wire logic regRd,
	input wire logic [15:0] regRdData,
	input wire logic [2:0] prodWr,
	input wire logic [2:0] conRd,
	input wire logic [2:0][15:0] conRdData,
	input wire logic [2:0] dataValid,
	input wire logic mapCycleDone
);
	// One domain, so one clock and one reset for every property
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	// First edge out of reset still shows the reset values
	AST_RST_VALUES: assert property ($rose(rst_n) |-> regRdData == 16'h0000
		&& dataValid == 3'h7 && !mapCycleDone)
		else $error("outputs not at reset values");
	// Read data is held until the next read
	AST_RD_HOLD: assert property (!regRd |=> $stable(regRdData))
		else $error("read data moved without a read");
	// Consumer data is held until the next consumer read
	AST_CON_HOLD: assert property (conRd == 3'h0 |=> $stable(conRdData))
		else $error("consumer data moved without a read");
	// A full pass takes far longer than eight cycles
	AST_DONE_GAP: assert property (mapCycleDone |=> !mapCycleDone [*8])
		else $error("map pass ended too soon");
	// A delivery always leaves that producer valid
	AST_VALID_ON_DELIVERY: assert property (prodWr != 3'h0 |=>
		(dataValid & $past(prodWr)) == $past(prodWr))
		else $error("delivery did not make data valid");
	// Validity only returns through a delivery, a register write or reset
	AST_RISE_CAUSE: assert property ((dataValid & ~$past(dataValid)
		& ~$past(prodWr)) != 3'h0 |-> $past(regWr) || !$past(rst_n))
		else $error("data became valid without cause");
	// Status word mirrors the validity flags seen at the read
	AST_STATUS: assert property (regRd && regAddr == rsdm_pkg::CFG_STATUS
		|=> regRdData[2:0] == $past(dataValid))
		else $error("status does not show validity");
	// Top of the register space is not implemented
	AST_UNMAPPED: assert property (regRd && regAddr >= 17'h0F000
		|=> regRdData == 16'h0000)
		else $error("unmapped read not zero");
	// Main scenarios
	cover property (mapCycleDone);
	cover property ($fell(dataValid[1]));
	cover property (regRd && regAddr == rsdm_pkg::CFG_STATUS);
endmodule
bind rsdm_register_store rsdm_checker i_chk (.clock(clock), .rst_n(rst_n),
	.regAddr(regAddr), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
	.prodWr(prodWr), .conRd(conRd), .conRdData(conRdData),
	.dataValid(dataValid), .mapCycleDone(mapCycleDone));
`default_nettype wire

// >>> verification/rsdm_partner.sv
// Far-side model: producers and consumers of process data
`timescale 1ns/1ps
`default_nettype none
module rsdm_partner (
	input wire logic clock,
	output var logic [2:0] prodWr,
	output var logic [2:0][7:0] prodAddr,
	output var logic [2:0][1:0] prodSize,
	output var logic [2:0][31:0] prodData,
	output var logic [2:0] conRd,
	output var logic [2:0][7:0] conAddr,
	input wire logic [2:0][15:0] conRdData
);
	// Quiet lines at time zero
	initial begin
		prodWr = 3'h0;
		prodAddr = '0;
		prodSize = '0;
		prodData = '0;
		conRd = 3'h0;
		conAddr = '0;
	end
	// One delivery into a producer's input area
	task automatic produce(input int p, input logic [7:0] a,
		input logic [1:0] s, input logic [31:0] d);
		@(posedge clock);
		prodWr[p] <= 1'b1;
		prodAddr[p] <= a;
		prodSize[p] <= s;
		prodData[p] <= d;
		@(posedge clock);
		prodWr[p] <= 1'b0;
		// Released data turns over, so it never looks fresh
		prodData[p] <= ~d;
	endtask
	// One consumer read, answer taken in the following cycle
	task automatic consume(input int c, input logic [7:0] a,
		output logic [15:0] v);
		@(posedge clock);
		conRd[c] <= 1'b1;
		conAddr[c] <= a;
		@(posedge clock);
		conRd[c] <= 1'b0;
		#1;
		v = conRdData[c];
	endtask
endmodule
`default_nettype wire

// >>> verification/tb.sv
// Self-checking bench for the register store and data mapper
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic clock;
	logic rst_n;
	logic [16:0] regAddr;
	logic [15:0] regWrData;
	logic regWr;
	logic regRd;
	logic [15:0] regRdData;
	logic [2:0] prodWr;
	logic [2:0][7:0] prodAddr;
	logic [2:0][1:0] prodSize;
	logic [2:0][31:0] prodData;
	logic [2:0] conRd;
	logic [2:0][7:0] conAddr;
	logic [2:0][15:0] conRdData;
	logic [2:0] dataValid;
	logic mapCycleDone;
	int errors = 0;
	int n_tests = 0;
	int cycles = 0;
	logic [15:0] v;
	// Short tick keeps validity times to a few cycles
	rsdm_register_store #(.AREA_WORDS(256), .TICK_DIV(4)) i_dut (
		.clock(clock), .rst_n(rst_n), .regAddr(regAddr),
		.regWrData(regWrData), .regWr(regWr), .regRd(regRd),
		.regRdData(regRdData), .prodWr(prodWr), .prodAddr(prodAddr),
		.prodSize(prodSize), .prodData(prodData), .conRd(conRd),
		.conAddr(conAddr), .conRdData(conRdData), .dataValid(dataValid),
		.mapCycleDone(mapCycleDone));
	rsdm_partner i_far (.clock(clock), .prodWr(prodWr), .prodAddr(prodAddr),
		.prodSize(prodSize), .prodData(prodData), .conRd(conRd),
		.conAddr(conAddr), .conRdData(conRdData));
	// 200 MHz clock
	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end
	// Hang guard, far above the expected run length
	always @(posedge clock) begin
		cycles++;
		if (cycles == 20000) begin
			errors++;
			wrap_up();
		end
	end
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	// Single-cycle register write
	task automatic reg_wr(input logic [16:0] a, input logic [15:0] d);
		@(posedge clock);
		regWr <= 1'b1;
		regAddr <= a;
		regWrData <= d;
		@(posedge clock);
		regWr <= 1'b0;
	endtask
	// Single-cycle read, data taken in the following cycle
	task automatic reg_rd(input logic [16:0] a, output logic [15:0] d);
		@(posedge clock);
		regRd <= 1'b1;
		regAddr <= a;
		@(posedge clock);
		regRd <= 1'b0;
		#1;
		d = regRdData;
	endtask
	// Rest of the current pass, one full pass, then all but the tail of a third: a pass first
	// rewrites words that its extended entries patch later, so the next
	// read must be sampled at the edge that ends the pass
	task automatic wait_done();
		int k;
		int seen;
		int len;
		seen = 0;
		len = 0;
		for (k = 0; k < 2000 && seen < 2; k++) begin
			@(posedge clock);
			#1;
			if (seen == 1) len++;
			if (mapCycleDone === 1'b1) seen++;
		end
		if (seen < 2) begin
			errors++;
			$display("mismatch at %0t: map pass never ended", $time);
		end
		repeat (len - 2) @(posedge clock);
	endtask
	task automatic t_reset();
		#1;
		check(regRdData, 16'h0000);
		reg_rd(rsdm_pkg::CFG_STATUS, v);
		check({13'h0000, v[2:0]}, 16'h0007);
		reg_rd(rsdm_pkg::REG_LAST, v);
		check(v, 16'h0000);
	endtask
	// Two fieldbus simple entries, one swapped, one entry each for the other ports, plus one extended entry on top
	task automatic t_map();
		logic [15:0] exp [5] = '{16'h1244, 16'hABCD, 16'h00C3, 16'h8877,
			16'h6655};
		reg_wr(rsdm_pkg::CFG_SMAP, 16'h1401);
		reg_wr(rsdm_pkg::CFG_SMAP + 17'h00001, 16'h0003);
		reg_wr(rsdm_pkg::CFG_SMAP + 17'h00002, 16'h1001);
		reg_wr(rsdm_pkg::CFG_SMAP + 17'h00003, rsdm_pkg::SWAP_FLAG | 16'h0002);
		reg_wr(rsdm_pkg::CFG_SMAP + 17'h00010, 16'h1402);
		reg_wr(rsdm_pkg::CFG_SMAP + 17'h00011, 16'h0001);
		reg_wr(rsdm_pkg::CFG_SMAP + 17'h00020, 16'h1401);
		reg_wr(rsdm_pkg::CFG_SMAP + 17'h00021, 16'h0001);
		reg_wr(rsdm_pkg::CFG_EMAP, 16'h2801);
		reg_wr(rsdm_pkg::CFG_EMAP + 17'h00001, 16'h1401);
		reg_wr(rsdm_pkg::CFG_EMAP + 17'h00002, 16'h0004);
		reg_wr(rsdm_pkg::CFG_EMAP + 17'h00003, 16'h0004);
		reg_wr(rsdm_pkg::CFG_RESTART, 16'h0001);
		i_far.produce(1, 8'h00, 2'h1, 32'h00001234);
		i_far.produce(1, 8'h01, 2'h3, 32'h0000ABCD);
		i_far.produce(1, 8'h02, 2'h0, 32'h000077C3);
		i_far.produce(1, 8'hFF, 2'h1, 32'h00000F0F);
		i_far.produce(2, 8'h00, 2'h2, 32'h55667788);
		reg_rd(17'h01401, v);
		check(v, 16'h1234);
		reg_rd(17'h01403, v);
		check(v, 16'h00C3);
		reg_rd(rsdm_pkg::SDP_IN_LAST, v);
		check(v, 16'h0F0F);
		reg_rd(17'h01002, v);
		check(v, 16'h5566);
		wait_done();
		for (int i = 0; i < 5; i++) begin
			i_far.consume(0, 8'(i), v);
			check(v, exp[i]);
		end
		i_far.consume(1, 8'h00, v);
		check(v, 16'hABCD);
		i_far.consume(2, 8'h00, v);
		check(v, 16'h1234);
		wait_done();
		reg_rd(17'h02801, v);
		check(v, 16'h1244);
	endtask
	// Edits wait for restart; an empty entry shifts the next one down
	task automatic t_live_edit();
		reg_wr(rsdm_pkg::CFG_SMAP + 17'h00001, 16'h0000);
		wait_done();
		i_far.consume(0, 8'h00, v);
		check(v, 16'h1244);
		reg_wr(rsdm_pkg::CFG_RESTART, 16'h0001);
		wait_done();
		i_far.consume(0, 8'h00, v);
		check(v, 16'h8847);
		i_far.consume(0, 8'h01, v);
		check(v, 16'h6655);
	endtask
	// Serial port producer goes stale; fieldbus consumer fills with ones
	task automatic t_validity();
		reg_wr(rsdm_pkg::CFG_SMAP + 17'h00001, 16'h0003);
		reg_wr(rsdm_pkg::CFG_VALID_TIME + 17'h00001, 16'h0002);
		reg_wr(rsdm_pkg::CFG_POLICY, {14'h0000, rsdm_pkg::POL_ONES});
		reg_wr(rsdm_pkg::CFG_POLICY + 17'h00001, {14'h0000, rsdm_pkg::POL_KEEP});
		reg_wr(rsdm_pkg::CFG_POLICY + 17'h00002, {14'h0000, rsdm_pkg::POL_ZERO});
		reg_wr(rsdm_pkg::CFG_RESTART, 16'h0001);
		i_far.produce(1, 8'h00, 2'h1, 32'h00001234);
		#1;
		check({15'h0000, dataValid[1]}, 16'h0001);
		repeat (20) @(posedge clock);
		#1;
		check({15'h0000, dataValid[1]}, 16'h0000);
		check({15'h0000, dataValid[2]}, 16'h0001);
		reg_rd(rsdm_pkg::CFG_STATUS, v);
		check({13'h0000, v[2:0]}, 16'h0005);
		wait_done();
		i_far.consume(0, 8'h00, v);
		check(v, 16'hFFFF);
		i_far.consume(0, 8'h03, v);
		check(v, 16'h8877);
		i_far.consume(1, 8'h00, v);
		check(v, 16'hABCD);
		i_far.consume(2, 8'h00, v);
		check(v, 16'h0000);
		reg_wr(rsdm_pkg::CFG_RESTART, 16'h0001);
		wait_done();
		i_far.consume(0, 8'h01, v);
		check(v, 16'hFFFF);
		// Clearing the time disables the timer at once
		reg_wr(rsdm_pkg::CFG_VALID_TIME + 17'h00001, 16'h0000);
		#1;
		check({15'h0000, dataValid[1]}, 16'h0001);
		repeat (2) @(posedge clock);
	endtask
	task automatic wrap_up();
		$display("comparisons %0d, errors %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// Reset for ten cycles, then the scenarios in turn
	initial begin
		rst_n = 1'b0;
		regAddr = 17'h00000;
		regWrData = 16'h0000;
		regWr = 1'b0;
		regRd = 1'b0;
		repeat (10) @(posedge clock);
		rst_n <= 1'b1;
		t_reset();
		t_map();
		t_live_edit();
		t_validity();
		wrap_up();
	end
endmodule
`default_nettype wire
